// ==== hdl/cwc_pkg.sv ====
package cwc_pkg;
  // transceiver mode field, two bits; upper bit set means monitored modes
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_WAKE = 2'h1;
  localparam logic [1:0] MODE_NORMAL = 2'h2;
  localparam logic [1:0] MODE_RXONLY = 2'h3;
  localparam int MODE_UV_BIT = 1;

  // host device operating modes
  typedef enum logic [2:0] {
    HOST_NORMAL,
    HOST_STOP,
    HOST_SLEEP,
    HOST_RESTART,
    HOST_FAILSAFE
  } cwc_host_e;

  // bus termination selection
  typedef enum logic [1:0] {
    TERM_FLOAT,
    TERM_HALF,
    TERM_GND,
    TERM_FIXED
  } cwc_term_e;

  // register map, word offsets on the plain port
  localparam logic [3:0] ADDR_MODE = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h1;
  localparam logic [3:0] ADDR_WAKE = 4'h2;
  localparam logic [3:0] ADDR_CONFIG = 4'h3;
  localparam int ST_BUSFAIL = 0;
  localparam int ST_UV = 1;
  localparam int ST_WAKE = 2;
  localparam int WK_BUS = 0;
  localparam int CFG_WDWAKE = 0;
  localparam logic [7:0] RD_ZERO = 8'h00;

  // time constants in ns, cycle counts derived at 100 MHz
  localparam int CLK_NS = 10;
  localparam int T_EN_NS = 8000;
  localparam int T_WAKE_MIN_NS = 500;
  localparam int T_WAKE_MAX_NS = 1800000;
  localparam int T_SILENCE_NS = 600000;
  localparam int T_TXTO_NS = 1000000;
  localparam int T_CLAMP_NS = 2000000;
  localparam int CYC_EN = (T_EN_NS + CLK_NS - 1) / CLK_NS;
  localparam int CYC_WAKE_MIN = (T_WAKE_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int CYC_WAKE_MAX = T_WAKE_MAX_NS / CLK_NS;
  localparam int CYC_SILENCE = (T_SILENCE_NS + CLK_NS - 1) / CLK_NS;
  localparam int CYC_TXTO = (T_TXTO_NS + CLK_NS - 1) / CLK_NS;
  localparam int CYC_CLAMP = (T_CLAMP_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 20;

  // bus side of the transceiver
  typedef struct packed {
    logic txDominant;
    logic txEnable;
    cwc_term_e term;
  } cwc_bus_s;
endpackage : cwc_pkg

// ==== hdl/cwc_transceiver_ctrl.sv ====
`timescale 1ns/1ps
module cwc_transceiver_ctrl #(
  parameter logic [1:0] MODE_OFF_CODE = cwc_pkg::MODE_OFF,
  parameter logic [1:0] MODE_NORMAL_CODE = cwc_pkg::MODE_NORMAL,
  parameter logic [1:0] MODE_RXONLY_CODE = cwc_pkg::MODE_RXONLY,
  parameter int EN_CYCLES = cwc_pkg::CYC_EN,
  parameter int WAKE_MIN_CYCLES = cwc_pkg::CYC_WAKE_MIN,
  parameter int WAKE_MAX_CYCLES = cwc_pkg::CYC_WAKE_MAX,
  parameter int SILENCE_CYCLES = cwc_pkg::CYC_SILENCE,
  parameter int TXTO_CYCLES = cwc_pkg::CYC_TXTO,
  parameter int CLAMP_CYCLES = cwc_pkg::CYC_CLAMP
) (
  input wire logic ref_clk, // system clock
  input wire logic reset_n, // synchronous reset, active low
  input wire logic [3:0] regAddr, // register address
  input wire logic [7:0] regWdata, // write data
  input wire logic regWrite, // write strobe
  input wire logic regRead, // read strobe
  output logic [7:0] regRdata, // read data, cycle after strobe
  input wire cwc_pkg::cwc_host_e hostMode, // host device mode
  input wire logic watchdogEnabled, // watchdog currently on
  input wire logic tx_data_in, // transmit pin, low is dominant
  input wire logic busDominant, // receiver comparator output
  input wire logic transceiver_supply, // supply above threshold
  output logic rx_data_out, // receive pin
  output logic irq_out_low, // interrupt, active low
  output logic restartReq, // one-cycle request to enter Restart
  output logic watchdogEnableReq, // one-cycle watchdog enable request
  output cwc_pkg::cwc_bus_s busCtrl // driver and termination controls
);
  localparam logic [1:0] MODE_WAKE_CODE = cwc_pkg::MODE_WAKE;
  localparam logic [cwc_pkg::CNT_W-1:0] CNT_ONE = 20'h0_0001;

  // pin inputs pass two flip-flops
  logic txSync1, txSync2, busSync1, busSync2, supSync1, supSync2;
  always_ff @(posedge ref_clk) begin
    txSync1 <= tx_data_in;
    txSync2 <= txSync1;
    busSync1 <= busDominant;
    busSync2 <= busSync1;
    supSync1 <= transceiver_supply;
    supSync2 <= supSync1;
  end
  wire txLow = !txSync2;
  wire busDom = busSync2;
  wire supplyOk = supSync2;

  logic [1:0] mode_reg;
  logic wdWake_reg, busFail_reg, uv_reg, wakeStat_reg, wakeSeen_reg;
  logic irqPend_reg;
  cwc_pkg::cwc_host_e hostPrev_reg;

  // register decode
  wire wrMode = regWrite && regAddr == cwc_pkg::ADDR_MODE;
  wire wrStatus = regWrite && regAddr == cwc_pkg::ADDR_STATUS;
  wire wrWake = regWrite && regAddr == cwc_pkg::ADDR_WAKE;
  wire wrConfig = regWrite && regAddr == cwc_pkg::ADDR_CONFIG;
  wire [1:0] reqMode = regWdata[1:0];
  wire hostNormStop = hostMode == cwc_pkg::HOST_NORMAL ||
                      hostMode == cwc_pkg::HOST_STOP;
  wire hostFailSafe = hostMode == cwc_pkg::HOST_FAILSAFE;
  wire wakeAllowed = hostNormStop || hostMode == cwc_pkg::HOST_SLEEP ||
                     hostMode == cwc_pkg::HOST_RESTART;
  // modes not allowed by the host mode are silently dropped
  wire modeOk = (reqMode == MODE_OFF_CODE) ||
                ((reqMode == MODE_NORMAL_CODE ||
                  reqMode == MODE_RXONLY_CODE) && hostNormStop) ||
                (reqMode == MODE_WAKE_CODE && wakeAllowed);
  wire modeWrite = wrMode && modeOk;
  wire [1:0] modeNext = hostFailSafe ? MODE_WAKE_CODE :
                        modeWrite ? reqMode : mode_reg;
  wire modeChange = modeNext != mode_reg;
  wire isNormal = mode_reg == MODE_NORMAL_CODE;
  wire isRxOnly = mode_reg == MODE_RXONLY_CODE;
  wire isWake = mode_reg == MODE_WAKE_CODE;
  wire uvMonitor = mode_reg[cwc_pkg::MODE_UV_BIT];
  wire uvActive = uvMonitor && !supplyOk;

  // host entering Stop, Sleep or Fail-Safe rearms wake detection
  wire hostEnter = hostMode != hostPrev_reg &&
                   (hostMode == cwc_pkg::HOST_STOP ||
                    hostMode == cwc_pkg::HOST_SLEEP || hostFailSafe);
  wire rearm = modeChange || hostEnter;

  // enable delay and transmit gating
  logic [cwc_pkg::CNT_W-1:0] enCnt_reg, toCnt_reg, clampCnt_reg;
  logic [cwc_pkg::CNT_W-1:0] silCnt_reg, phCnt_reg;
  logic txArmed_reg, toTrip_reg;
  wire enDone = enCnt_reg == '0;
  // a low seen before the delay ends blocks until the pin returns high
  wire txArmedNext = !isNormal ? 1'b0 :
                     (enDone && !txLow) ? 1'b1 : txArmed_reg;
  wire toExpire = isNormal && txLow &&
                  toCnt_reg == TXTO_CYCLES[cwc_pkg::CNT_W-1:0];
  wire toTripNext = toExpire ? 1'b1 : txLow ? toTrip_reg : 1'b0;
  // cut the driver in the very cycle the time-out expires, not one later
  wire driveOk = isNormal && txArmed_reg && !toTrip_reg && !toExpire &&
                 !uvActive;
  wire clampExpire = (isNormal || isRxOnly) && busDom &&
                     clampCnt_reg == CLAMP_CYCLES[cwc_pkg::CNT_W-1:0];

  // wake pattern detector: dom, rec, dom phases within the window
  typedef enum logic [1:0] {WP_IDLE, WP_DOM1, WP_REC, WP_DOM2} cwc_wp_e;
  cwc_wp_e wp_reg, wpNext;
  wire phMin = phCnt_reg >= WAKE_MIN_CYCLES[cwc_pkg::CNT_W-1:0];
  wire phMinX = phCnt_reg > WAKE_MIN_CYCLES[cwc_pkg::CNT_W-1:0];
  wire phMax = phCnt_reg >= WAKE_MAX_CYCLES[cwc_pkg::CNT_W-1:0];
  logic wakeHit;
  always_comb begin
    wpNext = wp_reg;
    wakeHit = 1'b0;
    case (wp_reg)
      WP_IDLE: if (busDom) wpNext = WP_DOM1;
      WP_DOM1: begin
        if (phMax) wpNext = WP_IDLE;
        else if (!busDom) wpNext = phMin ? WP_REC : WP_IDLE;
      end
      WP_REC: begin
        if (phMax) wpNext = WP_IDLE;
        else if (busDom) wpNext = phMinX ? WP_DOM2 : WP_DOM1;
      end
      WP_DOM2: begin
        if (phMax) wpNext = WP_IDLE;
        else if (phMin) begin
          wpNext = WP_IDLE;
          wakeHit = 1'b1;
        end else if (!busDom) wpNext = WP_IDLE;
      end
      default: wpNext = WP_IDLE;
    endcase
  end
  wire wpRun = isWake && !wakeSeen_reg && !rearm;
  wire wakeEvent = wpRun && wakeHit;
  wire phReset = wpNext != wp_reg || wp_reg == WP_IDLE;

  // wake consequences depend on host mode
  wire wakeIrq = wakeEvent && hostNormStop;
  wire wakeRestart = wakeEvent && !hostNormStop;
  wire wdReq = wakeEvent && hostMode == cwc_pkg::HOST_STOP &&
               wdWake_reg && !watchdogEnabled;

  wire wakeSeenNext = rearm ? 1'b0 : wakeEvent ? 1'b1 : wakeSeen_reg;
  // set wins over software clear on every sticky flag
  wire busFailNext = (toExpire || clampExpire) ? 1'b1 :
                     (wrStatus && regWdata[cwc_pkg::ST_BUSFAIL]) ? 1'b0 :
                     busFail_reg;
  wire uvNext = uvActive ? 1'b1 :
                (wrStatus && regWdata[cwc_pkg::ST_UV]) ? 1'b0 : uv_reg;
  wire wakeStatNext = wakeEvent ? 1'b1 :
                      (wrWake && regWdata[cwc_pkg::WK_BUS]) ? 1'b0 :
                      wakeStat_reg;
  wire irqPendNext = wakeIrq ? 1'b1 :
                     (wrWake && regWdata[cwc_pkg::WK_BUS]) ? 1'b0 :
                     irqPend_reg;

  // receive pin
  wire rxNext = (isNormal || isRxOnly) ? !busDom :
                (isWake && (wakeSeen_reg || wakeEvent)) ? 1'b0 :
                1'b1;

  // termination
  logic silDone_reg;
  cwc_pkg::cwc_term_e termNext;
  assign termNext = isNormal ? cwc_pkg::TERM_HALF :
                    isRxOnly ? (uvActive ? cwc_pkg::TERM_FIXED :
                                cwc_pkg::TERM_HALF) :
                    isWake ? (wakeSeen_reg ? cwc_pkg::TERM_FIXED :
                              silDone_reg ? cwc_pkg::TERM_GND :
                              cwc_pkg::TERM_FLOAT) :
                    cwc_pkg::TERM_FLOAT;
  wire silNext = isWake && !modeChange &&
                 (silDone_reg ||
                  silCnt_reg == SILENCE_CYCLES[cwc_pkg::CNT_W-1:0]);

  wire [7:0] statusWord = {5'h0_0, irqPend_reg, uv_reg, busFail_reg};
  wire [7:0] rdMux = regAddr == cwc_pkg::ADDR_MODE ? {6'h00, mode_reg} :
                     regAddr == cwc_pkg::ADDR_STATUS ? statusWord :
                     regAddr == cwc_pkg::ADDR_WAKE ? {7'h00, wakeStat_reg} :
                     regAddr == cwc_pkg::ADDR_CONFIG ? {7'h00, wdWake_reg} :
                     cwc_pkg::RD_ZERO;

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      mode_reg <= MODE_OFF_CODE;
      hostPrev_reg <= cwc_pkg::HOST_NORMAL;
      wdWake_reg <= 1'b0;
      busFail_reg <= 1'b0;
      uv_reg <= 1'b0;
      wakeStat_reg <= 1'b0;
      wakeSeen_reg <= 1'b0;
      irqPend_reg <= 1'b0;
      txArmed_reg <= 1'b0;
      toTrip_reg <= 1'b0;
      silDone_reg <= 1'b0;
      wp_reg <= WP_IDLE;
    end else begin
      mode_reg <= modeNext;
      hostPrev_reg <= hostMode;
      if (wrConfig) wdWake_reg <= regWdata[cwc_pkg::CFG_WDWAKE];
      busFail_reg <= busFailNext;
      uv_reg <= uvNext;
      wakeStat_reg <= wakeStatNext;
      wakeSeen_reg <= wakeSeenNext;
      irqPend_reg <= irqPendNext;
      txArmed_reg <= txArmedNext;
      toTrip_reg <= toTripNext;
      silDone_reg <= silNext;
      wp_reg <= wpRun ? wpNext : WP_IDLE;
    end
  end

  // counters
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      enCnt_reg <= '0;
      toCnt_reg <= '0;
      clampCnt_reg <= '0;
      silCnt_reg <= '0;
      phCnt_reg <= '0;
    end else begin
      if (modeChange) enCnt_reg <= EN_CYCLES[cwc_pkg::CNT_W-1:0];
      else if (!enDone) enCnt_reg <= enCnt_reg - CNT_ONE;
      if (!(isNormal && txLow)) toCnt_reg <= '0;
      else if (!toExpire) toCnt_reg <= toCnt_reg + CNT_ONE;
      if (!((isNormal || isRxOnly) && busDom)) clampCnt_reg <= '0;
      else if (!clampExpire) clampCnt_reg <= clampCnt_reg + CNT_ONE;
      if (!isWake || modeChange) silCnt_reg <= '0;
      else if (!silDone_reg) silCnt_reg <= silCnt_reg + CNT_ONE;
      if (phReset || !wpRun) phCnt_reg <= '0;
      else if (!phMax) phCnt_reg <= phCnt_reg + CNT_ONE;
    end
  end

  // outputs, all registered
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      regRdata <= cwc_pkg::RD_ZERO;
      rx_data_out <= 1'b1;
      irq_out_low <= 1'b1;
      restartReq <= 1'b0;
      watchdogEnableReq <= 1'b0;
      busCtrl <= '{txDominant: 1'b0, txEnable: 1'b0,
                   term: cwc_pkg::TERM_FLOAT};
    end else begin
      regRdata <= regRead ? rdMux : cwc_pkg::RD_ZERO;
      rx_data_out <= rxNext;
      irq_out_low <= !irqPendNext;
      restartReq <= wakeRestart;
      watchdogEnableReq <= wdReq;
      busCtrl.txEnable <= driveOk;
      busCtrl.txDominant <= driveOk && txLow;
      busCtrl.term <= termNext;
    end
  end

  // the clamp filter must be longer than the transmit time-out
  if (CLAMP_CYCLES <= TXTO_CYCLES) begin : g_clamp_check
    $error("clamp filter must exceed transmit time-out");
  end

  property p_off_idle;
    @(posedge ref_clk) disable iff (!reset_n)
      mode_reg == MODE_OFF_CODE |=> !busCtrl.txEnable && rx_data_out;
  endproperty
  a_off_idle: assert property (p_off_idle)
    else $error("off mode not idle");

  property p_mode_gate;
    @(posedge ref_clk) disable iff (!reset_n)
      wrMode && reqMode == MODE_NORMAL_CODE && !hostNormStop && !hostFailSafe
      |=> mode_reg == $past(mode_reg);
  endproperty
  a_mode_gate: assert property (p_mode_gate)
    else $error("normal accepted in wrong host mode");

  property p_tx_follow;
    @(posedge ref_clk) disable iff (!reset_n)
      driveOk |=> busCtrl.txDominant == $past(txLow);
  endproperty
  a_tx_follow: assert property (p_tx_follow)
    else $error("bus does not follow transmit input");

  property p_en_block;
    @(posedge ref_clk) disable iff (!reset_n)
      isNormal && !enDone |=> !busCtrl.txDominant;
  endproperty
  a_en_block: assert property (p_en_block)
    else $error("dominant sent during enable delay");

  property p_rx_only;
    @(posedge ref_clk) disable iff (!reset_n)
      isRxOnly |=> !busCtrl.txEnable && rx_data_out == !$past(busDom);
  endproperty
  a_rx_only: assert property (p_rx_only)
    else $error("receive-only mode wrong");

  property p_wake_rx;
    @(posedge ref_clk) disable iff (!reset_n)
      wakeEvent ##1 isWake |-> !rx_data_out;
  endproperty
  a_wake_rx: assert property (p_wake_rx)
    else $error("receive output not low after wake");

  property p_wake_irq;
    @(posedge ref_clk) disable iff (!reset_n)
      wakeEvent |=> (irq_out_low == !$past(hostNormStop)) && wakeStat_reg;
  endproperty
  a_wake_irq: assert property (p_wake_irq)
    else $error("wake signalling wrong");

  property p_timeout;
    @(posedge ref_clk) disable iff (!reset_n)
      toExpire |=> busFail_reg && !busCtrl.txDominant ##1 !busCtrl.txDominant;
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("time-out did not force recessive");

  property p_gnd_term;
    @(posedge ref_clk) disable iff (!reset_n)
      $rose(isWake) |-> (busCtrl.term != cwc_pkg::TERM_GND) [*2];
  endproperty
  a_gnd_term: assert property (p_gnd_term)
    else $error("ground termination before silence time");

  property p_to_release;
    @(posedge ref_clk) disable iff (!reset_n)
      toTrip_reg && !txLow |=> !toTrip_reg;
  endproperty
  a_to_release: assert property (p_to_release)
    else $error("transmitter not re-enabled after time-out");

  property p_clamp_flag;
    @(posedge ref_clk) disable iff (!reset_n)
      clampExpire |=> busFail_reg;
  endproperty
  a_clamp_flag: assert property (p_clamp_flag)
    else $error("bus clamping not flagged");

  property p_uv_drive;
    @(posedge ref_clk) disable iff (!reset_n)
      uvActive |=> !busCtrl.txEnable && uv_reg;
  endproperty
  a_uv_drive: assert property (p_uv_drive)
    else $error("undervoltage did not stop the driver");

  property p_wake_restart;
    @(posedge ref_clk) disable iff (!reset_n)
      wakeEvent && hostMode == cwc_pkg::HOST_SLEEP |=> restartReq;
  endproperty
  a_wake_restart: assert property (p_wake_restart)
    else $error("wake in sleep gave no restart request");
endmodule : cwc_transceiver_ctrl

// ==== sim/cwc_ctrl_model.sv ====
`timescale 1ns/1ps
module cwc_ctrl_model #(
  parameter int EN_CYCLES = 4
) (
  input wire logic ref_clk, // system clock
  input wire logic reset_n, // sync reset, active low
  input wire logic modeSet, // mode register just written
  input wire logic early, // send dominant inside the delay
  input wire logic wantDom, // bench asks for dominant
  output logic tx_data_in // transmit pin, low is dominant
);
  int holdCnt;
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      holdCnt <= 0;
      tx_data_in <= 1'b1;
    end else begin
      // margin covers the pin synchronisers
      if (modeSet) holdCnt <= EN_CYCLES + 4;
      else if (holdCnt > 0) holdCnt <= holdCnt - 1;
      tx_data_in <= !(wantDom && (early || holdCnt == 0));
    end
  end
endmodule : cwc_ctrl_model

// ==== sim/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  localparam int EN = 4;
  localparam int SIL = 10;
  localparam int TXTO = 20;
  localparam int CLAMP = 40;
  logic ref_clk = 0, reset_n = 0, regWrite = 0, regRead = 0;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWdata = 8'h00, regRdata, rd;
  cwc_pkg::cwc_host_e hostMode = cwc_pkg::HOST_NORMAL;
  logic watchdogEnabled = 0, busDominant = 0, supply = 1, tx_data_in;
  logic rx_data_out, irq_out_low, restartReq, watchdogEnableReq;
  logic modeSet = 0, early = 0, wantDom = 0, b;
  cwc_pkg::cwc_bus_s busCtrl;
  int bad_count = 0, compares = 0, rsCnt = 0, wdCnt = 0, v1, v2, v3;
  logic [31:0] seed = 32'h0000_005F;

  cwc_transceiver_ctrl #(.EN_CYCLES(EN), .WAKE_MIN_CYCLES(5),
    .WAKE_MAX_CYCLES(50), .SILENCE_CYCLES(SIL), .TXTO_CYCLES(TXTO),
    .CLAMP_CYCLES(CLAMP)) dut_u (.ref_clk(ref_clk), .reset_n(reset_n),
    .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
    .regRead(regRead), .regRdata(regRdata), .hostMode(hostMode),
    .watchdogEnabled(watchdogEnabled), .tx_data_in(tx_data_in),
    .busDominant(busDominant), .transceiver_supply(supply),
    .rx_data_out(rx_data_out), .irq_out_low(irq_out_low),
    .restartReq(restartReq), .watchdogEnableReq(watchdogEnableReq),
    .busCtrl(busCtrl));
  cwc_ctrl_model #(.EN_CYCLES(EN)) ctrl_u (.ref_clk(ref_clk),
    .reset_n(reset_n), .modeSet(modeSet), .early(early),
    .wantDom(wantDom), .tx_data_in(tx_data_in));

  initial forever #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    if (restartReq === 1'b1) rsCnt++;
    if (watchdogEnableReq === 1'b1) wdCnt++;
  end

  function automatic logic [7:0] bit8(input logic x);
    return {7'h00, x};
  endfunction : bit8
  function automatic logic [7:0] term8(input cwc_pkg::cwc_term_e t);
    return {6'h00, t};
  endfunction : term8
  function automatic int rnd(input int lo, input int span);
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return lo + int'(seed[15:0]) % span;
  endfunction : rnd
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cyc
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    modeSet <= (a == cwc_pkg::ADDR_MODE);
    @(posedge ref_clk);
    regWrite <= 1'b0;
    modeSet <= 1'b0;
  endtask : wr
  task automatic rdr(input logic [3:0] a);
    @(posedge ref_clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge ref_clk);
    regRead <= 1'b0;
    #1 rd = regRdata;
  endtask : rdr
  task automatic setMode(input logic [1:0] m);
    wr(cwc_pkg::ADDR_MODE, {6'h00, m});
  endtask : setMode
  task automatic host(input cwc_pkg::cwc_host_e h);
    @(posedge ref_clk) hostMode <= h;
    cyc(3);
  endtask : host
  task automatic drv(input logic d, input int n);
    @(posedge ref_clk) wantDom <= d;
    cyc(n);
  endtask : drv
  task automatic bus(input logic d, input int n);
    @(posedge ref_clk) busDominant <= d;
    cyc(n);
  endtask : bus
  // random lengths stay inside the detection window
  task automatic wake_pattern(input int d1, input int r, input int d2);
    bus(1'b1, d1);
    bus(1'b0, r);
    bus(1'b1, d2);
    bus(1'b0, 8);
  endtask : wake_pattern
  task automatic rwup();
    v1 = rnd(6, 35);
    v2 = rnd(7, 35);
    v3 = rnd(6, 35);
    wake_pattern(v1, v2, v3);
  endtask : rwup
  task automatic stop_test();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test

  // whole run is about a thousand cycles
  initial begin
    #200000;
    bad_count++;
    stop_test();
  end

  initial begin
    repeat (12) @(posedge ref_clk);
    reset_n <= 1'b1;
    cyc(1);
    rdr(cwc_pkg::ADDR_MODE);
    chk(rd, {6'h00, cwc_pkg::MODE_OFF});
    chk(term8(busCtrl.term), term8(cwc_pkg::TERM_FLOAT));
    wake_pattern(10, 10, 10);
    chk(bit8(rx_data_out & irq_out_low), 8'h01);
    rdr(4'hF);
    chk(rd, cwc_pkg::RD_ZERO);
    $display("test reset done");
    host(cwc_pkg::HOST_SLEEP);
    setMode(cwc_pkg::MODE_NORMAL);
    setMode(cwc_pkg::MODE_RXONLY);
    rdr(cwc_pkg::ADDR_MODE);
    chk(rd, {6'h00, cwc_pkg::MODE_OFF});
    host(cwc_pkg::HOST_STOP);
    early <= 1'b1;
    drv(1'b1, 1);
    setMode(cwc_pkg::MODE_NORMAL);
    cyc(EN + 8);
    early <= 1'b0;
    rdr(cwc_pkg::ADDR_MODE);
    chk(rd, {6'h00, cwc_pkg::MODE_NORMAL});
    chk(term8(busCtrl.term), term8(cwc_pkg::TERM_HALF));
    chk(bit8(busCtrl.txDominant), 8'h00);
    drv(1'b0, 4);
    drv(1'b1, 5);
    chk(bit8(busCtrl.txDominant), 8'h01);
    cyc(TXTO);
    chk(bit8(busCtrl.txDominant), 8'h00);
    rdr(cwc_pkg::ADDR_STATUS);
    chk(bit8(rd[cwc_pkg::ST_BUSFAIL]), 8'h01);
    rdr(cwc_pkg::ADDR_MODE);
    chk(rd, {6'h00, cwc_pkg::MODE_NORMAL});
    drv(1'b0, 4);
    drv(1'b1, 5);
    chk(bit8(busCtrl.txDominant), 8'h01);
    drv(1'b0, 5);
    chk(bit8(busCtrl.txDominant), 8'h00);
    $display("test transmit done");
    @(posedge ref_clk) supply <= 1'b0;
    cyc(6);
    chk(bit8(busCtrl.txEnable), 8'h00);
    rdr(cwc_pkg::ADDR_STATUS);
    chk(bit8(rd[cwc_pkg::ST_UV]), 8'h01);
    @(posedge ref_clk) supply <= 1'b1;
    cyc(EN + 8);
    chk(bit8(busCtrl.txEnable), 8'h01);
    for (int m = 0; m < 2; m++) begin
      setMode(m ? cwc_pkg::MODE_RXONLY : cwc_pkg::MODE_NORMAL);
      @(posedge ref_clk) supply <= (m == 0);
      for (int i = 0; i < 12; i++) begin
        v1 = rnd(0, 2);
        b = v1[0];
        bus(b, 5);
        chk(bit8(rx_data_out), bit8(!b));
      end
      if (m == 1) chk(bit8(busCtrl.txEnable), 8'h00);
    end
    $display("test receive done");
    @(posedge ref_clk) supply <= 1'b1;
    bus(1'b0, 2);
    wr(cwc_pkg::ADDR_STATUS, 8'h03);
    bus(1'b1, TXTO + 10);
    bus(1'b0, 2);
    rdr(cwc_pkg::ADDR_STATUS);
    chk(bit8(rd[cwc_pkg::ST_BUSFAIL]), 8'h00);
    bus(1'b1, CLAMP + 10);
    bus(1'b0, 2);
    rdr(cwc_pkg::ADDR_STATUS);
    chk(bit8(rd[cwc_pkg::ST_BUSFAIL]), 8'h01);
    rdr(cwc_pkg::ADDR_MODE);
    chk(rd, {6'h00, cwc_pkg::MODE_RXONLY});
    setMode(cwc_pkg::MODE_OFF);
    wr(cwc_pkg::ADDR_STATUS, 8'h03);
    @(posedge ref_clk) supply <= 1'b0;
    cyc(6);
    rdr(cwc_pkg::ADDR_STATUS);
    chk(bit8(rd[cwc_pkg::ST_UV]), 8'h00);
    @(posedge ref_clk) supply <= 1'b1;
    $display("test faults done");
    host(cwc_pkg::HOST_NORMAL);
    setMode(cwc_pkg::MODE_WAKE);
    cyc(2);
    chk(term8(busCtrl.term), term8(cwc_pkg::TERM_FLOAT));
    cyc(SIL + 5);
    chk(term8(busCtrl.term), term8(cwc_pkg::TERM_GND));
    wake_pattern(2, 10, 2);
    chk(bit8(rx_data_out), 8'h01);
    rwup();
    chk(bit8(rx_data_out | irq_out_low), 8'h00);
    rdr(cwc_pkg::ADDR_WAKE);
    chk(bit8(rd[cwc_pkg::WK_BUS]), 8'h01);
    rdr(cwc_pkg::ADDR_MODE);
    chk(rd, {6'h00, cwc_pkg::MODE_WAKE});
    chk(term8(busCtrl.term), term8(cwc_pkg::TERM_FIXED));
    wr(cwc_pkg::ADDR_WAKE, 8'h01);
    cyc(2);
    chk(bit8(irq_out_low), 8'h01);
    chk(bit8(rx_data_out), 8'h00);
    wr(cwc_pkg::ADDR_CONFIG, 8'h01);
    host(cwc_pkg::HOST_STOP);
    rwup();
    chk(8'(wdCnt), 8'h01);
    chk(bit8(irq_out_low), 8'h00);
    wr(cwc_pkg::ADDR_WAKE, 8'h01);
    host(cwc_pkg::HOST_SLEEP);
    rwup();
    chk(8'(rsCnt), 8'h01);
    chk(bit8(irq_out_low | rx_data_out), 8'h01);
    host(cwc_pkg::HOST_RESTART);
    rwup();
    chk(8'(rsCnt), 8'h01);
    setMode(cwc_pkg::MODE_OFF);
    cyc(3);
    chk(bit8(rx_data_out), 8'h01);
    setMode(cwc_pkg::MODE_WAKE);
    cyc(SIL + 5);
    rwup();
    chk(8'(rsCnt), 8'h02);
    setMode(cwc_pkg::MODE_OFF);
    host(cwc_pkg::HOST_FAILSAFE);
    rdr(cwc_pkg::ADDR_MODE);
    chk(rd, {6'h00, cwc_pkg::MODE_WAKE});
    $display("test wake done");
    stop_test();
  end
endmodule : tb_top
